// File: hw/uart_defs.vh
`ifndef UART_DEFS_VH
`define UART_DEFS_VH

// Register addresses on the 8-bit register port
`define ADDR_POWER_CTRL 8'h87
`define ADDR_SERIAL_CTRL 8'h98
`define ADDR_RX_DATA 8'h99
`define ADDR_BAUD_RELOAD 8'h9A
`define ADDR_BAUD_GEN_CTRL 8'h9B
`define ADDR_SLAVE_ADDR 8'hA9
`define ADDR_SLAVE_MASK 8'hB9
`define ADDR_TIMER2_CTRL 8'hC8
`define ADDR_IRQ_STATUS 8'hF0
`define ADDR_IRQ_MASK 8'hF1

// serial_control_reg fields
`define SC_MODE0_BIT 7
`define SC_MODE1_BIT 6
`define SC_MP_BIT 5
`define SC_REN_BIT 4
`define SC_TB8_BIT 3
`define SC_RB8_BIT 2
`define SC_TI_BIT 1
`define SC_DONE_BIT 0

// Other control fields
`define PC_DOUBLER_BIT 7
`define T2_TX_SEL_BIT 4
`define T2_RX_SEL_BIT 5
`define BG_RUN_BIT 4
`define BG_TX_SEL_BIT 3
`define BG_RX_SEL_BIT 2
`define BG_FAST_BIT 1

// Interrupt status bits
`define IRQ_RX_DONE_BIT 0
`define IRQ_DROP_BIT 1

// Serial modes
`define MODE_SHIFT 2'h0
`define MODE_UART8 2'h1
`define MODE_UART9_FIX 2'h2
`define MODE_UART9_VAR 2'h3

// Reset values
`define RST_BYTE 8'h00

// Receiver timing in 16x sample ticks
`define SAMPLE_MID 4'h7
`define SAMPLE_LAST 4'hF
`define DATA_BITS 3'h7

// Fixed-rate mode divider end counts: one sample tick every count + 1 clocks
`define FIX_DIV_X1 2'h3
`define FIX_DIV_X2 2'h1

// Low-speed prescaler of the internal generator
`define GEN_PRESCALE 3'h5

`endif

// File: hw/addr_matcher.v
`include "uart_defs.vh"

module addr_matcher (
  input wire [7:0] rx_addr, // Received address byte
  input wire [7:0] slave_address, // Individual address
  input wire [7:0] slave_address_mask, // Don't-care mask, zero bits ignored
  output wire given_hit, // Matches given address
  output wire bcast_hit, // Matches broadcast address
  output wire match // Either one
);

  function compare;
    input [7:0] value;
    input [7:0] ref_addr;
    input [7:0] care;
    begin
      compare = ((value ^ ref_addr) & care) == `RST_BYTE;
    end
  endfunction

  wire [7:0] bcast = slave_address | slave_address_mask;

  assign given_hit = compare(rx_addr, slave_address, slave_address_mask);
  assign bcast_hit = compare(rx_addr, bcast, bcast);
  assign match = given_hit | bcast_hit;

endmodule

// File: hw/baud_gen.v
`include "uart_defs.vh"

module baud_gen #(
  parameter WIDTH = 8
) (
  input wire mclk, // Peripheral clock
  input wire rst_n, // Async reset, active low
  input wire run, // Generator enable
  input wire gen_speed_mode, // 1: count every clock, 0: every sixth
  input wire [WIDTH-1:0] baud_reload_value, // Reload value
  output reg ovf_reg // One-cycle overflow pulse
);

  reg [2:0] pre_reg;
  reg [WIDTH-1:0] cnt_reg;
  wire step = gen_speed_mode | (pre_reg == `GEN_PRESCALE);
  wire wrap = &cnt_reg;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 3'h0;
      cnt_reg <= {WIDTH{1'b0}};
      ovf_reg <= 1'b0;
    end else if (!run) begin
      pre_reg <= 3'h0;
      cnt_reg <= baud_reload_value;
      ovf_reg <= 1'b0;
    end else begin
      pre_reg <= step ? 3'h0 : pre_reg + 3'h1;
      ovf_reg <= step & wrap;
      if (step) begin
        // Counts reload..max, so one overflow per (2^WIDTH - reload) steps
        cnt_reg <= wrap ? baud_reload_value : cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// File: hw/uart_addr_match_baud_select.v
// Contract
// - Address matching active when multiproc_enable set, except in mode 0
// - Matching on: flag only for own address frames
// - Mode 1: stop bit acts as ninth bit
// - Mode 0 ignores multiproc_enable entirely
// - Given address: mask zeros are don't-care
// - All-ones mask compares every address bit
// - Broadcast is address OR mask, zeros ignored
// - Accept given or broadcast address match
// - Reset clears address and mask to zero
// - Tx clock in modes 1 and 3: generator, else timer 2, else timer 1
// - Rx clock chosen likewise, independent of tx
// - Generator overflows from reloading counter
// - Rate per doubler, speed bit, 32, 256-reload
// - Two mode bits select one of four modes
`include "uart_defs.vh"

module uart_addr_match_baud_select (
  input wire mclk, // Peripheral clock
  input wire rst_n, // Async reset, active low
  input wire [7:0] addr, // Register address
  input wire [7:0] wdata, // Register write data
  input wire wr_en, // Write strobe
  input wire rd_en, // Read strobe
  output reg [7:0] rdata_reg, // Read data, cycle after rd_en
  input wire rxd, // Serial receive pin
  input wire timer1_ovf, // Timer 1 overflow pulse
  input wire timer2_ovf, // Timer 2 overflow pulse
  output reg tx_tick_reg, // Tx 16x sample clock enable
  output reg rx_tick_reg, // Rx 16x sample clock enable
  output reg rx_done_flag_reg, // Receive-done flag
  output reg irq_reg // Level interrupt
);

  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_NINTH = 3'h3;
  localparam ST_STOP = 3'h4;

  // Software-visible state
  reg [7:0] serial_control_reg;
  reg [7:0] slave_address_reg;
  reg [7:0] slave_address_mask_reg;
  reg [7:0] baud_reload_reg;
  reg [7:0] baud_gen_control_reg;
  reg [7:0] power_control_reg;
  reg [7:0] timer2_control_reg;
  reg [7:0] rx_data_reg;
  reg [1:0] irq_status_reg;
  reg [1:0] irq_mask_reg;

  // Tick generation state
  reg t1_half_reg;
  reg gen_half_reg;
  reg [1:0] fix_cnt_reg;

  // Receiver state
  reg rxd_meta_reg;
  reg rxd_sync_reg;
  reg line_prev_reg;
  reg [2:0] state_reg;
  reg [3:0] phase_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg ninth_reg;

  wire [1:0] mode = {serial_control_reg[`SC_MODE0_BIT],
                     serial_control_reg[`SC_MODE1_BIT]};
  wire nine_bit = mode[1];
  wire ren = serial_control_reg[`SC_REN_BIT];
  wire doubler = power_control_reg[`PC_DOUBLER_BIT];
  wire gen_ovf;
  wire given_hit;
  wire bcast_hit;
  wire addr_match;

  // Multiprocessor handling needs the enable bit and any mode but shift
  wire mp_active = serial_control_reg[`SC_MP_BIT] & (mode != `MODE_SHIFT);

  baud_gen #(
    .WIDTH(8)
  ) u_baud_gen (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(baud_gen_control_reg[`BG_RUN_BIT]),
    .gen_speed_mode(baud_gen_control_reg[`BG_FAST_BIT]),
    .baud_reload_value(baud_reload_reg),
    .ovf_reg(gen_ovf)
  );

  addr_matcher u_addr_matcher (
    .rx_addr(shift_reg),
    .slave_address(slave_address_reg),
    .slave_address_mask(slave_address_mask_reg),
    .given_hit(given_hit),
    .bcast_hit(bcast_hit),
    .match(addr_match)
  );

  // A timer 1 or generator overflow is divided by two unless doubled, which
  // turns (256 - reload) counts into a 16x tick of a bit period of 32 x (256 - reload) counts.
  wire t1_tick = timer1_ovf & (doubler | t1_half_reg);
  wire gen_tick = gen_ovf & (doubler | gen_half_reg);
  wire fix_tick = (fix_cnt_reg == `FIX_DIV_X1) | (doubler & (fix_cnt_reg == `FIX_DIV_X2));

  function pick_tick;
    input gen_sel;
    input t2_sel;
    input [1:0] md;
    input tg;
    input t2;
    input t1;
    input tf;
    begin
      case (md)
        `MODE_UART8,
        `MODE_UART9_VAR: pick_tick = gen_sel ? tg : (t2_sel ? t2 : t1);
        `MODE_UART9_FIX: pick_tick = tf;
        // Shift mode runs off its own fixed clock, not a baud tick
        default: pick_tick = 1'b0;
      endcase
    end
  endfunction

  wire tx_tick = pick_tick(baud_gen_control_reg[`BG_TX_SEL_BIT],
                           timer2_control_reg[`T2_TX_SEL_BIT], mode,
                           gen_tick, timer2_ovf, t1_tick, fix_tick);
  wire rx_tick = pick_tick(baud_gen_control_reg[`BG_RX_SEL_BIT],
                           timer2_control_reg[`T2_RX_SEL_BIT], mode,
                           gen_tick, timer2_ovf, t1_tick, fix_tick);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      t1_half_reg <= 1'b0;
      gen_half_reg <= 1'b0;
      fix_cnt_reg <= 2'h0;
      tx_tick_reg <= 1'b0;
      rx_tick_reg <= 1'b0;
    end else begin
      if (timer1_ovf) begin
        t1_half_reg <= ~t1_half_reg;
      end
      if (gen_ovf) begin
        gen_half_reg <= ~gen_half_reg;
      end
      fix_cnt_reg <= fix_tick ? 2'h0 : fix_cnt_reg + 2'h1;
      // Registered for flop outputs: users see each tick one cycle late
      tx_tick_reg <= tx_tick;
      rx_tick_reg <= rx_tick;
    end
  end

  // Receiver: samples at the middle of each bit on the 16x tick
  wire line = rxd_sync_reg;
  // A level test would restart on a low stop bit; only a fall starts a frame
  wire line_fell = line_prev_reg & ~line;
  wire at_mid = rx_tick & (phase_reg == `SAMPLE_MID);
  wire at_last = rx_tick & (phase_reg == `SAMPLE_LAST);
  wire stop_seen = (state_reg == ST_STOP) & at_last;
  // Mode 1 has no ninth bit: the stop bit stands in for it
  wire bit9 = nine_bit ? ninth_reg : line;
  // With matching on, only an address frame (bit9 high, which in mode 1
  // also means a valid stop) naming this device may raise the flag.
  wire frame_ok = ~mp_active | (bit9 & addr_match);
  wire accept = stop_seen & frame_ok & ~rx_done_flag_reg;
  wire drop = stop_seen & ~accept;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      line_prev_reg <= 1'b1;
      state_reg <= ST_IDLE;
      phase_reg <= 4'h0;
      bit_cnt_reg <= 3'h0;
      shift_reg <= `RST_BYTE;
      ninth_reg <= 1'b0;
    end else begin
      rxd_meta_reg <= rxd;
      rxd_sync_reg <= rxd_meta_reg;
      line_prev_reg <= line;
      if (rx_tick) begin
        phase_reg <= phase_reg + 4'h1;
      end
      case (state_reg)
        ST_IDLE: begin
          phase_reg <= 4'h0;
          // Shift mode reception is not handled here
          if (ren && mode != `MODE_SHIFT && line_fell) begin
            state_reg <= ST_START;
          end
        end
        ST_START: begin
          if (at_mid) begin
            phase_reg <= 4'h0;
            bit_cnt_reg <= 3'h0;
            // A glitch shorter than half a bit is not a start bit
            state_reg <= line ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (at_last) begin
            shift_reg <= {line, shift_reg[7:1]};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == `DATA_BITS) begin
              state_reg <= nine_bit ? ST_NINTH : ST_STOP;
            end
          end
        end
        ST_NINTH: begin
          if (at_last) begin
            ninth_reg <= line;
            state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          // Sampled mid-bit, so the flag rises before the line is idle again
          if (at_last) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Register port
  wire wr_sc = wr_en & (addr == `ADDR_SERIAL_CTRL);
  wire wr_status = wr_en & (addr == `ADDR_IRQ_STATUS);
  wire [1:0] events = {drop, accept};

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      serial_control_reg <= `RST_BYTE;
      slave_address_reg <= `RST_BYTE;
      slave_address_mask_reg <= `RST_BYTE;
      baud_reload_reg <= `RST_BYTE;
      baud_gen_control_reg <= `RST_BYTE;
      power_control_reg <= `RST_BYTE;
      timer2_control_reg <= `RST_BYTE;
      rx_data_reg <= `RST_BYTE;
      irq_status_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      rx_done_flag_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      if (wr_en) begin
        case (addr)
          `ADDR_SERIAL_CTRL: serial_control_reg <= wdata;
          `ADDR_SLAVE_ADDR: slave_address_reg <= wdata;
          `ADDR_SLAVE_MASK: slave_address_mask_reg <= wdata;
          `ADDR_BAUD_RELOAD: baud_reload_reg <= wdata;
          `ADDR_BAUD_GEN_CTRL: baud_gen_control_reg <= wdata;
          `ADDR_POWER_CTRL: power_control_reg <= wdata;
          `ADDR_TIMER2_CTRL: timer2_control_reg <= wdata;
          `ADDR_IRQ_MASK: irq_mask_reg <= wdata[1:0];
          default: ;
        endcase
      end
      // Hardware set beats a software write in the same cycle
      if (accept) begin
        rx_data_reg <= shift_reg;
        serial_control_reg[`SC_RB8_BIT] <= bit9;
      end
      if (accept) begin
        rx_done_flag_reg <= 1'b1;
      end else if (wr_sc) begin
        rx_done_flag_reg <= wdata[`SC_DONE_BIT];
      end
      irq_status_reg <= events | (irq_status_reg & ~(wr_status ? wdata[1:0] : 2'h0));
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Read data stands for one cycle only, so a stale value never reads twice
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `RST_BYTE;
    end else if (rd_en) begin
      case (addr)
        `ADDR_SERIAL_CTRL: rdata_reg <= {serial_control_reg[7:1], rx_done_flag_reg};
        `ADDR_RX_DATA: rdata_reg <= rx_data_reg;
        `ADDR_SLAVE_ADDR: rdata_reg <= slave_address_reg;
        `ADDR_SLAVE_MASK: rdata_reg <= slave_address_mask_reg;
        `ADDR_BAUD_RELOAD: rdata_reg <= baud_reload_reg;
        `ADDR_BAUD_GEN_CTRL: rdata_reg <= baud_gen_control_reg;
        `ADDR_POWER_CTRL: rdata_reg <= power_control_reg;
        `ADDR_TIMER2_CTRL: rdata_reg <= timer2_control_reg;
        `ADDR_IRQ_STATUS: rdata_reg <= {6'h00, irq_status_reg};
        `ADDR_IRQ_MASK: rdata_reg <= {6'h00, irq_mask_reg};
        default: rdata_reg <= `RST_BYTE;
      endcase
    end else begin
      rdata_reg <= `RST_BYTE;
    end
  end

endmodule

// File: tb/uart_checks_properties.sv
`include "uart_defs.vh"
module uart_checks_properties (
  input wire mclk, // Clock
  input wire rst_n, // Reset
  input wire [7:0] addr, // Address
  input wire [7:0] wdata, // Write data
  input wire wr_en, // Write strobe
  input wire rd_en, // Read strobe
  input wire [7:0] rdata_reg, // Read data
  input wire tx_tick_reg, // Tx tick
  input wire rx_tick_reg, // Rx tick
  input wire rx_done_flag_reg, // Flag
  input wire irq_reg // Interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  reg [7:0] sc_reg, sa_reg, sm_reg, im_reg;
  reg dbl_reg;
  // Shadows of what software wrote, since the bodies are hidden
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sc_reg <= 8'h00;
      sa_reg <= 8'h00;
      sm_reg <= 8'h00;
      im_reg <= 8'h00;
      dbl_reg <= 1'b0;
    end else if (wr_en) begin
      if (addr == `ADDR_SERIAL_CTRL) sc_reg <= wdata;
      if (addr == `ADDR_SLAVE_ADDR) sa_reg <= wdata;
      if (addr == `ADDR_SLAVE_MASK) sm_reg <= wdata;
      if (addr == `ADDR_IRQ_MASK) im_reg <= wdata;
      if (addr == `ADDR_POWER_CTRL) dbl_reg <= wdata[`PC_DOUBLER_BIT];
    end
  end
  wire m0 = sc_reg[7:6] == `MODE_SHIFT;
  wire m2 = sc_reg[7:6] == `MODE_UART9_FIX && !dbl_reg;
  wire ctl_wr = wr_en && (addr == `ADDR_SERIAL_CTRL || addr == `ADDR_POWER_CTRL);
  sequence s_read(logic [7:0] a);
    rd_en && addr == a;
  endsequence
  sequence s_period4;
    !rx_tick_reg [*3] ##1 rx_tick_reg;
  endsequence
  a_rdata_idle_zero: assert property (!$past(rd_en) |-> rdata_reg == 8'h00)
    else $error("read data not idle");
  a_slave_address_read: assert property (s_read(`ADDR_SLAVE_ADDR) |=> rdata_reg == sa_reg)
    else $error("slave address read wrong");
  a_mask_read: assert property (s_read(`ADDR_SLAVE_MASK) |=> rdata_reg == sm_reg)
    else $error("mask read wrong");
  a_flag_sticky: assert property (rx_done_flag_reg && !(wr_en && addr == `ADDR_SERIAL_CTRL)
    |=> rx_done_flag_reg)
    else $error("flag dropped without write");
  a_flag_write_set: assert property (wr_en && addr == `ADDR_SERIAL_CTRL && wdata[0]
    |=> rx_done_flag_reg)
    else $error("flag write ignored");
  a_flag_at_stop: assert property ($rose(rx_done_flag_reg) && !$past(wr_en) |-> rx_tick_reg
    || $past(rx_tick_reg) || $past(rx_tick_reg, 2) || $past(rx_tick_reg, 3))
    else $error("flag rose off a sample tick");
  a_mode0_quiet: assert property (m0 && $past(m0) && $past(m0, 2) && $past(m0, 3)
    |-> !tx_tick_reg && !rx_tick_reg)
    else $error("tick in shift mode");
  a_mode2_period: assert property (rx_tick_reg && m2 && $past(m2, 3) && !ctl_wr
    |=> s_period4 or (##[0:3] ctl_wr))
    else $error("fixed mode tick period wrong");
  a_irq_masked: assert property (irq_reg |-> $past(im_reg) != 8'h00)
    else $error("interrupt while fully masked");
endmodule

// File: tb/serial_peer.sv
module serial_peer (
  input wire mclk, // Clock
  output logic rxd // Line into the receiver, idle high
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd = 1'b1;
  // Start, nb data bits LSB first, then stop; a low stop only when asked for
  task automatic send(input logic [8:0] d, input int nb, input logic stop, input int bc);
    logic b;
    for (int i = 0; i < nb + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : stop;
      @(posedge mclk);
      rxd <= b;
      repeat (bc - 1) @(posedge mclk);
    end
    @(posedge mclk);
    rxd <= 1'b1;
  endtask
endmodule

// File: tb/tb.sv
`include "uart_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, tmr_run = 1'b0;
  logic timer1_ovf = 1'b0, timer2_ovf = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rd_val, cnt = 8'h00, sc, sa, mk, by;
  logic [3:0] b9, ex;
  wire rxd, tx_tick_reg, rx_tick_reg, rx_done_flag_reg, irq_reg;
  wire [7:0] rdata_reg;
  int err_total = 0, n_compared = 0, ntx, nrx;
  logic [39:0] rows [14] = '{40'hB0F1FAF011, 40'hB0F1FAF310, 40'hB0F1FAFF11, 40'hB0F2FDFB10,
    40'hB0F1FAFB11, 40'hB056FF5611, 40'hB056FF5710, 40'hB056FF5600, 40'h9056FF1201,
    40'h3000001210, 40'hB000003C11, 40'hB056FC5511, 40'hB056FCFE11, 40'hB056FC5A10};
  always #50 mclk = ~mclk;
  uart_addr_match_baud_select i_uart_addr_match_baud_select (.mclk(mclk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_reg(rdata_reg),
    .rxd(rxd), .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf), .tx_tick_reg(tx_tick_reg),
    .rx_tick_reg(rx_tick_reg), .rx_done_flag_reg(rx_done_flag_reg), .irq_reg(irq_reg));
  serial_peer i_serial_peer (.mclk(mclk), .rxd(rxd));
  // Timer 1 every 2nd clock, timer 2 every 10th, so the sources differ in rate
  always @(posedge mclk) begin
    cnt <= (cnt == 8'h09) ? 8'h00 : cnt + 8'h01;
    timer1_ovf <= tmr_run & cnt[0];
    timer2_ovf <= tmr_run & (cnt == 8'h00);
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 rd_val = rdata_reg;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic count96();
    ntx = 0;
    nrx = 0;
    repeat (96) begin
      @(posedge mclk);
      #1 ntx += tx_tick_reg;
      nrx += rx_tick_reg;
    end
  endtask
  function automatic logic [7:0] src(input int n);
    src = n >= 30 ? 8'h01 : n >= 6 ? 8'h02 : n >= 1 ? 8'h03 : 8'h00;
  endfunction
  task automatic report_and_stop();
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    wr(`ADDR_IRQ_MASK, 8'h01);
    foreach (rows[k]) begin
      {sc, sa, mk, by, b9, ex} = rows[k];
      wr(`ADDR_SLAVE_ADDR, sa);
      wr(`ADDR_SLAVE_MASK, mk);
      wr(`ADDR_SERIAL_CTRL, sc);
      wr(`ADDR_IRQ_STATUS, 8'hFF);
      i_serial_peer.send({b9[0], by}, 9, 1'b1, 64);
      repeat (8) @(posedge mclk);
      #1 chk({7'h00, rx_done_flag_reg}, {4'h0, ex});
      chk({7'h00, irq_reg}, {4'h0, ex});
      rd(`ADDR_RX_DATA);
      if (ex[0]) chk(rd_val, by);
    end
    tmr_run <= 1'b1;
    wr(`ADDR_SERIAL_CTRL, 8'hC0);
    wr(`ADDR_POWER_CTRL, 8'h80);
    wr(`ADDR_BAUD_RELOAD, 8'hE0);
    for (int i = 0; i < 16; i++) begin
      wr(`ADDR_TIMER2_CTRL, {2'h0, i[1], i[0], 4'h0});
      wr(`ADDR_BAUD_GEN_CTRL, {3'h0, 1'h1, i[2], i[3], 2'h2});
      repeat (40) @(posedge mclk);
      count96();
      chk(src(ntx), i[2] ? 8'h03 : i[0] ? 8'h02 : 8'h01);
      chk(src(nrx), i[3] ? 8'h03 : i[1] ? 8'h02 : 8'h01);
      if (i[2]) chk(ntx[7:0], 8'(96 / (256 - 8'hE0)));
    end
    wr(`ADDR_POWER_CTRL, 8'h00);
    wr(`ADDR_BAUD_RELOAD, 8'hFE);
    // Stop the generator so it restarts from the new reload value
    wr(`ADDR_BAUD_GEN_CTRL, 8'h0C);
    wr(`ADDR_BAUD_GEN_CTRL, 8'h1C);
    repeat (60) @(posedge mclk);
    count96();
    chk(ntx[7:0], 8'(96 / (6 * (256 - 8'hFE) * 2)));
    chk(nrx[7:0], 8'(96 / (6 * (256 - 8'hFE) * 2)));
    @(posedge mclk);
    tmr_run <= 1'b0;
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`ADDR_SLAVE_ADDR);
    chk(rd_val, 8'h00);
    rd(`ADDR_SLAVE_MASK);
    chk(rd_val, 8'h00);
    rd(8'h55);
    chk(rd_val, 8'h00);
    // Mode 1 off the generator: 4 clocks per tick, so 64 clocks per bit
    wr(`ADDR_POWER_CTRL, 8'h80);
    wr(`ADDR_BAUD_RELOAD, 8'hFC);
    wr(`ADDR_BAUD_GEN_CTRL, 8'h16);
    wr(`ADDR_SLAVE_ADDR, 8'h56);
    wr(`ADDR_SLAVE_MASK, 8'hFF);
    wr(`ADDR_SERIAL_CTRL, 8'h70);
    i_serial_peer.send(9'h056, 8, 1'b0, 64);
    repeat (8) @(posedge mclk);
    #1 chk({7'h00, rx_done_flag_reg}, 8'h00);
    rd(`ADDR_IRQ_STATUS);
    chk(rd_val, 8'h02);
    i_serial_peer.send(9'h056, 8, 1'b1, 64);
    repeat (8) @(posedge mclk);
    #1 chk({7'h00, rx_done_flag_reg}, 8'h01);
    rd(`ADDR_SERIAL_CTRL);
    chk(rd_val, 8'h75);
    chk({7'h00, irq_reg}, 8'h00);
    wr(`ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, irq_reg}, 8'h01);
    wr(`ADDR_IRQ_STATUS, 8'hFF);
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, irq_reg}, 8'h00);
    wr(`ADDR_SERIAL_CTRL, 8'h70);
    #1 chk({7'h00, rx_done_flag_reg}, 8'h00);
    wr(`ADDR_SERIAL_CTRL, 8'h71);
    #1 chk({7'h00, rx_done_flag_reg}, 8'h01);
    report_and_stop();
  end
endmodule
bind uart_addr_match_baud_select uart_checks_properties i_chk (.mclk(mclk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_reg(rdata_reg),
  .tx_tick_reg(tx_tick_reg), .rx_tick_reg(rx_tick_reg),
  .rx_done_flag_reg(rx_done_flag_reg), .irq_reg(irq_reg));
